/* File: src/byte_lane_dram_ops.sv */
// host-side controller driving a multiplexed byte-lane dram
`timescale 1ns/1ns
// What this block does
// - lower byte write drives lower pins only
// - upper byte write drives upper pins only
// - word write drives all sixteen pins
// - refresh all 1024 rows every 16.4 ms
// - 500 us pause then eight row cycles
module byte_lane_dram_ops
   import dram_host_pkg::*;
#(
   parameter int unsigned PAUSE_CYCLES = PAUSE_CYC,
   parameter int unsigned REF_GAP      = REF_GAP_CYC
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              clk_en,
   // user request
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic [1:0]        req_lanes,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic                   init_done,
   // dram pins
   output logic                   row_strobe_n,
   output logic                   low_byte_col_strobe_n,
   output logic                   high_byte_col_strobe_n,
   output logic                   store_select_n,
   output logic                   drive_enable_n,
   output logic [MUX_W-1:0]       mux_address,
   input  wire logic [DATA_W-1:0] data_pins_in,
   output logic [DATA_W-1:0]      data_pins_out,
   output logic [DATA_W-1:0]      data_pins_oe
);
   typedef enum logic [1:0] {OP_ACC = 2'b00, OP_ROWREF = 2'b01, OP_CBR = 2'b11} op_e;

   phase_e            st_r;
   op_e               op_r;
   logic [2:0]        ph_cnt_r;
   logic [31:0]       pause_cnt_r;
   logic [31:0]       ref_cnt_r;
   logic              ref_due_r;
   logic [3:0]        init_cnt_r;
   logic              wr_r;
   logic [1:0]        lanes_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [MUX_W-1:0]  ref_row_r;
   logic [DATA_W-1:0] din_s1_r;
   logic [DATA_W-1:0] din_s2_r;
   logic              ph_end;
   logic              start_acc;
   logic              start_ref;

   assign ph_end    = (ph_cnt_r == PH_LAST);
   assign req_ready = clk_en && init_done && !ref_due_r && (st_r == ST_IDLE);
   assign start_acc = req_valid && req_ready && (req_lanes != 2'b00);
   // refresh wins over a new access; init cycles use row-only refresh
   // no row cycle at all until the power-up pause has run out
   assign start_ref = clk_en && (st_r == ST_IDLE) && (pause_cnt_r >= PAUSE_CYCLES)
                    && (!init_done || ref_due_r);

   // power-up pause
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pause_cnt_r <= 32'h0000_0000;
      else if (clk_en && !init_done && pause_cnt_r < PAUSE_CYCLES)
         pause_cnt_r <= pause_cnt_r + 32'h1;
   end

   // eight row-strobe cycles before normal use
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         init_cnt_r <= 4'h0;
         init_done  <= 1'b0;
      end
      else if (clk_en && st_r == ST_PRE && ph_end && !init_done)
      begin
         init_cnt_r <= init_cnt_r + 4'h1;
         init_done  <= (init_cnt_r + 4'h1 == INIT_LAST);
      end
   end

   // distributed refresh timer; row-only refresh walks all rows
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ref_cnt_r <= 32'h0000_0000;
         ref_due_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (ref_cnt_r >= REF_GAP - 1)
            ref_cnt_r <= 32'h0000_0000;
         else
            ref_cnt_r <= ref_cnt_r + 32'h1;
         // a new tick wins over the clear from the starting refresh
         if (init_done && ref_cnt_r >= REF_GAP - 1)
            ref_due_r <= 1'b1;
         else if (start_ref)
            ref_due_r <= 1'b0;
      end
   end

   // phase sequencer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_r     <= ST_IDLE;
         op_r     <= OP_ACC;
         ph_cnt_r <= 3'h0;
      end
      else if (clk_en)
      begin
         ph_cnt_r <= (st_r == ST_IDLE || ph_end) ? 3'h0 : ph_cnt_r + 3'h1;
         unique case (st_r)
            ST_IDLE:
               if (start_ref)
               begin
                  op_r <= OP_ROWREF;
                  st_r <= ST_ROW;
               end
               else if (start_acc)
               begin
                  op_r <= OP_ACC;
                  st_r <= ST_ROW;
               end
            ST_ROW:  if (ph_end) st_r <= (op_r == OP_ACC) ? ST_COL : ST_HOLD;
            ST_COL:  if (ph_end) st_r <= ST_HOLD;
            ST_HOLD: if (ph_end) st_r <= ST_PRE;
            ST_PRE:  if (ph_end) st_r <= ST_IDLE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // request capture and refresh row pointer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_r      <= 1'b0;
         lanes_r   <= 2'b00;
         addr_r    <= '0;
         wdata_r   <= '0;
         ref_row_r <= ROW_ZERO;
      end
      else if (clk_en)
      begin
         if (start_acc && !start_ref)
         begin
            wr_r    <= req_write;
            lanes_r <= req_lanes;
            addr_r  <= req_addr;
            wdata_r <= req_wdata;
         end
         if (st_r == ST_PRE && ph_end && op_r == OP_ROWREF)
            ref_row_r <= ref_row_r + 10'h001;
      end
   end

   // dram pin drive, all registered; stable through each phase
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         row_strobe_n           <= 1'b1;
         low_byte_col_strobe_n  <= 1'b1;
         high_byte_col_strobe_n <= 1'b1;
         store_select_n         <= 1'b1;
         drive_enable_n         <= 1'b1;
         mux_address            <= '0;
         data_pins_out          <= '0;
         data_pins_oe           <= '0;
      end
      else if (clk_en)
      begin
         row_strobe_n <= !(st_r == ST_ROW || st_r == ST_COL || st_r == ST_HOLD);
         // row address one cycle before row fall, column address on the same edge as column fall
         if (st_r == ST_IDLE)
            mux_address <= start_ref ? ref_row_r : req_addr[ADDR_W-1:MUX_W];
         else if (st_r == ST_ROW && ph_end)
            mux_address <= addr_r[MUX_W-1:0];
         if (st_r == ST_COL || (st_r == ST_ROW && ph_end && op_r == OP_ACC))
         begin
            low_byte_col_strobe_n  <= !(lanes_r[0] && ph_cnt_r != 3'h0 || st_r == ST_COL && lanes_r[0]);
            high_byte_col_strobe_n <= !(lanes_r[1] && ph_cnt_r != 3'h0 || st_r == ST_COL && lanes_r[1]);
         end
         else if (st_r == ST_HOLD && ph_end)
         begin
            low_byte_col_strobe_n  <= 1'b1;
            high_byte_col_strobe_n <= 1'b1;
         end
         // early write: store select low before column fall
         store_select_n <= !(op_r == OP_ACC && wr_r && (st_r == ST_ROW || st_r == ST_COL));
         drive_enable_n <= !(op_r == OP_ACC && !wr_r && (st_r == ST_COL || st_r == ST_HOLD));
         data_pins_out  <= wdata_r;
         // drive only the written lane, never during a read
         data_pins_oe[BYTE_W-1:0] <= {BYTE_W{op_r == OP_ACC && wr_r && lanes_r[0] &&
                                      (st_r == ST_ROW || st_r == ST_COL || st_r == ST_HOLD)}};
         data_pins_oe[DATA_W-1:BYTE_W] <= {BYTE_W{op_r == OP_ACC && wr_r && lanes_r[1] &&
                                      (st_r == ST_ROW || st_r == ST_COL || st_r == ST_HOLD)}};
      end
   end

   // read data synchroniser; sampled at the end of hold, lanes not read are zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         din_s1_r  <= '0;
         din_s2_r  <= '0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end
      else if (clk_en)
      begin
         din_s1_r  <= data_pins_in;
         din_s2_r  <= din_s1_r;
         rsp_valid <= (st_r == ST_HOLD && ph_end && op_r == OP_ACC && !wr_r);
         if (st_r == ST_HOLD && ph_end && op_r == OP_ACC && !wr_r)
            rsp_rdata <= din_s2_r & {{BYTE_W{lanes_r[1]}}, {BYTE_W{lanes_r[0]}}};
      end
   end

   chk_write_oe_off: assert property (@(posedge clk) disable iff (rst)
      !drive_enable_n |-> data_pins_oe == '0) else $error("bus driven during read");
   chk_lane_low: assert property (@(posedge clk) disable iff (rst)
      (!low_byte_col_strobe_n && !store_select_n) |-> !row_strobe_n && drive_enable_n
      && data_pins_oe[BYTE_W-1:0] == {BYTE_W{1'b1}})
      else $error("lower lane misdriven");
   chk_lane_high: assert property (@(posedge clk) disable iff (rst)
      data_pins_oe[DATA_W-1] |-> lanes_r[1] && wr_r) else $error("upper lane misdriven");
   chk_idle_open: assert property (@(posedge clk) disable iff (rst)
      row_strobe_n && $past(row_strobe_n) |-> data_pins_oe == '0)
      else $error("pins driven idle");
   chk_rowref_cas: assert property (@(posedge clk) disable iff (rst)
      op_r == OP_ROWREF |-> low_byte_col_strobe_n && high_byte_col_strobe_n)
      else $error("column strobe in refresh");
   chk_init_wait: assert property (@(posedge clk) disable iff (rst)
      !row_strobe_n |-> pause_cnt_r >= PAUSE_CYCLES || init_done)
      else $error("pause skipped");
   chk_ref_grant: assert property (@(posedge clk) disable iff (rst)
      $rose(ref_due_r) && st_r == ST_IDLE && clk_en |=> !ref_due_r || st_r != ST_IDLE)
      else $error("refresh not started");
   chk_col_after_row: assert property (@(posedge clk) disable iff (rst)
      $fell(low_byte_col_strobe_n) |-> !row_strobe_n) else $error("column before row");
   chk_no_rdy_init: assert property (@(posedge clk) disable iff (rst)
      !init_done |-> !req_ready) else $error("ready before init");
endmodule // byte_lane_dram_ops

/* File: src/dram_host_pkg.sv */
// constants and types for the multiplexed dram host controller
package dram_host_pkg;
   localparam int unsigned ADDR_W      = 20;
   localparam int unsigned MUX_W       = 10;
   localparam int unsigned DATA_W      = 16;
   localparam int unsigned BYTE_W      = 8;
   localparam int unsigned CLK_MHZ     = 100;
   // power-up pause and refresh interval
   localparam int unsigned PAUSE_US    = 500;
   localparam int unsigned REF_WIN_US  = 16400;
   localparam int unsigned ROWS        = 1024;
   localparam int unsigned INIT_CYCLES = 8;
   localparam int unsigned PAUSE_CYC   = PAUSE_US * CLK_MHZ;
   // one refresh per row, spread evenly; rounded down as a longest time
   localparam int unsigned REF_GAP_CYC = (REF_WIN_US * CLK_MHZ) / ROWS;
   // strobe phase length in clocks (row/column setup, hold, access)
   localparam int unsigned PHASE_CYC   = 4;
   localparam logic [2:0]  PH_LAST     = 3'(PHASE_CYC - 1);
   localparam logic [3:0]  INIT_LAST   = 4'(INIT_CYCLES);
   localparam logic [9:0]  ROW_ZERO    = 10'h000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ROW  = 3'b001,
      ST_COL  = 3'b011,
      ST_HOLD = 3'b010,
      ST_PRE  = 3'b110
   } phase_e;
endpackage

/* File: verif/dram_model.sv */
// behavioural byte-lane multiplexed dram, the far side of the host controller
`timescale 1ns/1ns
module dram_model
   import dram_host_pkg::*;
(
   // strobes and controls, all active low
   input  wire logic              clk,
   input  wire logic              rs_n,
   input  wire logic              ls_n,
   input  wire logic              hs_n,
   input  wire logic              wr_n,
   input  wire logic              oe_n,
   input  wire logic [MUX_W-1:0]  ma,
   // data lines
   input  wire logic [DATA_W-1:0] dq,
   output logic [DATA_W-1:0]      dq_drv,
   output logic [DATA_W-1:0]      dq_en
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [MUX_W-1:0]  row_r;
   logic              rp_r = 1'b1;
   logic              lp_r = 1'b1;
   logic              hp_r = 1'b1;
   logic              rd_r = 1'b0;
   logic [ADDR_W-1:0] a;
   // rd_r outlives a row rise while strobes stay low, as hidden refresh needs
   assign dq_en[7:0]  = {8{rd_r & !ls_n & wr_n & !oe_n}};
   assign dq_en[15:8] = {8{rd_r & !hs_n & wr_n & !oe_n}};
   always @(posedge clk)
   begin
      a = {row_r, ma};
      rp_r <= rs_n;
      lp_r <= ls_n;
      hp_r <= hs_n;
      // strobes already low as the row falls: internal row, no row captured
      if (!rs_n && rp_r && ls_n && hs_n)
         row_r <= ma;
      // first column fall inside an open row accesses the addressed word
      if (!rs_n && !rp_r && ((!ls_n && lp_r) || (!hs_n && hp_r)))
      begin
         if (!wr_n && !ls_n)
            mem[a][7:0] = dq[7:0];
         if (!wr_n && !hs_n)
            mem[a][15:8] = dq[15:8];
         dq_drv <= mem[a];
         rd_r <= wr_n;
      end
      if (rs_n && ls_n && hs_n)
         rd_r <= 1'b0;
   end
endmodule // dram_model

/* File: verif/tb_byte_lane_dram_ops.sv */
// self-checking bench for the byte-lane dram host controller
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t got %0h expected %0h", $time, g, e); end end
module tb_byte_lane_dram_ops
   import dram_host_pkg::*;
;
   localparam int unsigned PAUSE = 20;
   localparam int unsigned GAP   = 50;
   logic              clk       = 1'b0;
   logic              rst       = 1'b1;
   logic              clk_en    = 1'b1;
   logic              req_valid = 1'b0;
   logic              req_write = 1'b0;
   logic [1:0]        req_lanes = 2'h0;
   logic [ADDR_W-1:0] req_addr  = '0;
   logic [DATA_W-1:0] req_wdata = '0;
   logic [DATA_W-1:0] last_r    = '0;
   logic              req_ready, rsp_valid, init_done, rs_n, ls_n, hs_n, wr_n, oe_n;
   logic [MUX_W-1:0]  ma;
   logic [DATA_W-1:0] rsp_rdata, dq, d_out, d_oe, m_drv, m_en;
   int                err_count = 0;
   int                n_tests   = 0;
   always #5 clk = ~clk;
   // a released line never keeps its last level
   assign dq = (d_out & d_oe) | (m_drv & m_en & ~d_oe) | (~last_r & ~m_en & ~d_oe);
   always @(posedge clk) last_r <= dq;
   byte_lane_dram_ops #(.PAUSE_CYCLES(PAUSE), .REF_GAP(GAP)) u_dut (.clk(clk), .rst(rst),
      .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_lanes(req_lanes), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
      .row_strobe_n(rs_n), .low_byte_col_strobe_n(ls_n), .high_byte_col_strobe_n(hs_n),
      .store_select_n(wr_n), .drive_enable_n(oe_n), .mux_address(ma),
      .data_pins_in(dq), .data_pins_out(d_out), .data_pins_oe(d_oe));
   dram_model u_mem (.clk(clk), .rs_n(rs_n), .ls_n(ls_n), .hs_n(hs_n), .wr_n(wr_n),
      .oe_n(oe_n), .ma(ma), .dq(dq), .dq_drv(m_drv), .dq_en(m_en));
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [1:0] ln, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] r);
      int n;
      n = 0;
      req_write = w;
      req_lanes = ln;
      req_addr = 20'hABCDE;
      req_wdata = d;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      // a write has no answer, so wait for the next grant instead
      while ((w ? req_ready : rsp_valid) !== 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000)
      begin
         err_count++;
         complete_run();
      end
      r = rsp_rdata;
   endtask
   // counts row falls; stops early at init_done when asked
   task automatic watch(input logic to_init, input int lim, output int first,
                        output int falls, output logic cols, output logic seq);
      int c;
      logic prev;
      logic [MUX_W-1:0] last_ma;
      c = 0;
      first = 0;
      falls = 0;
      cols = 1'b0;
      seq = 1'b1;
      prev = 1'b1;
      last_ma = '0;
      while (!(to_init && init_done === 1'b1) && c < lim)
      begin
         @(negedge clk);
         c++;
         if (!rs_n && prev)
         begin
            falls++;
            if (first == 0)
               first = c;
            // refresh rows must step one by one to cover every row
            if (falls > 1 && ma !== last_ma + 10'h001)
               seq = 1'b0;
            last_ma = ma;
         end
         prev = rs_n;
         cols = cols | !ls_n | !hs_n;
      end
   endtask
   task automatic t_init;
      int first, falls;
      logic cols, seq;
      watch(1'b1, 3000, first, falls, cols, seq);
      `CHK(init_done, 1'b1)
      `CHK(first >= PAUSE, 1'b1)
      `CHK(falls >= 8, 1'b1)
      `CHK(cols, 1'b0)
      `CHK(seq, 1'b1)
      $display("test init done");
      if (init_done !== 1'b1)
         complete_run();
   endtask
   task automatic t_lanes;
      logic [DATA_W-1:0] r;
      xfer(1'b1, 2'h3, 16'hA5C3, r);
      `CHK(u_mem.mem[20'hABCDE], 16'hA5C3)
      xfer(1'b0, 2'h3, 16'h0000, r);
      `CHK(r, 16'hA5C3)
      xfer(1'b1, 2'h1, 16'hFF3C, r);
      `CHK(u_mem.mem[20'hABCDE], 16'hA53C)
      xfer(1'b0, 2'h1, 16'h0000, r);
      `CHK(r, 16'h003C)
      xfer(1'b1, 2'h2, 16'h7E99, r);
      `CHK(u_mem.mem[20'hABCDE], 16'h7E3C)
      xfer(1'b0, 2'h2, 16'h0000, r);
      `CHK(r, 16'h7E00)
      $display("test lanes done");
   endtask
   task automatic t_refresh;
      int first, falls;
      logic cols, seq;
      watch(1'b0, 3 * GAP, first, falls, cols, seq);
      `CHK(falls >= 2, 1'b1)
      `CHK(cols, 1'b0)
      `CHK(seq, 1'b1)
      $display("test refresh done");
   endtask
   // frozen clock enable must hold every strobe and control pin level, then resume cleanly
   task automatic t_freeze;
      logic [4:0]        pins;
      logic [DATA_W-1:0] r;
      @(negedge clk);
      clk_en = 1'b0;
      pins = {rs_n, ls_n, hs_n, wr_n, oe_n};
      repeat (2 * GAP) @(negedge clk);
      `CHK({rs_n, ls_n, hs_n, wr_n, oe_n, req_ready}, {pins, 1'b0})
      clk_en = 1'b1;
      xfer(1'b0, 2'h3, 16'h0000, r);
      `CHK(r, 16'h7E3C)
      $display("test freeze done");
   endtask
   initial
   begin
      repeat (4) @(negedge clk);
      `CHK({rs_n, ls_n, hs_n, init_done, req_ready, d_oe}, {3'h7, 2'h0, 16'h0000})
      repeat (4) @(negedge clk);
      rst = 1'b0;
      t_init();
      t_lanes();
      t_refresh();
      t_freeze();
      complete_run();
   end
endmodule // tb_byte_lane_dram_ops
